/* hw/dcira_pkg.sv */
// Package for the dual channel indirect register bank
package dcira_pkg;
    localparam int DCIRA_NUM_CH = 2;
    // Control register indices
    localparam logic [2:0] DCIRA_CR0 = 3'h0;
    localparam logic [2:0] DCIRA_CR1 = 3'h1;
    localparam logic [2:0] DCIRA_CR2 = 3'h2;
    localparam logic [2:0] DCIRA_CR3 = 3'h3;
    localparam logic [2:0] DCIRA_CR4 = 3'h4;
    localparam logic [2:0] DCIRA_CR5 = 3'h5;
    localparam logic [2:0] DCIRA_CR6 = 3'h6;
    localparam logic [2:0] DCIRA_CR7 = 3'h7;
    // Status register indices
    localparam logic [2:0] DCIRA_SR0 = 3'h0;
    localparam logic [2:0] DCIRA_SR1 = 3'h1;
    localparam logic [2:0] DCIRA_SR2 = 3'h2;
    // Main control register field positions, and the transmit enable bit of register 5
    localparam int DCIRA_PTR_LSB = 0;
    localparam int DCIRA_CMD_LSB = 3;
    localparam int DCIRA_CRC_LSB = 6;
    localparam int DCIRA_TX_EN_BIT = 3;
    // Commands
    localparam logic [2:0] DCIRA_CMD_NULL = 3'h0;
    localparam logic [2:0] DCIRA_CMD_RST_EXT = 3'h2;
    localparam logic [2:0] DCIRA_CMD_CH_RST = 3'h3;
    // Reset values
    localparam logic [7:0] DCIRA_REG_RST = 8'h00;
    localparam logic [2:0] DCIRA_PTR_RST = 3'h0;
    localparam logic DCIRA_MARK = 1'b1;

    typedef logic [7:0] dcira_byte_t;

    typedef struct packed {
        logic [1:0][2:0] ptr;
        logic [1:0][7:1][7:0] cr;
        dcira_byte_t shared_bus_interface_control;
        dcira_byte_t shared_status;
        logic [1:0] ext_latch;
        logic [1:0][7:0] ext_snap;
        dcira_byte_t rd_data;
    } dcira_state_t;
endpackage : dcira_pkg

/* hw/dcira_bank.sv */
// Two-channel indirect control and status register bank
`timescale 1ns/1ps
// Notes on behaviour
// - Control registers 1..7 are reached only through the channel's register pointer.
// - Each channel owns its control registers; register 2A exists once, shared.
// - Software or hardware reset clears the pointer; next write hits register 0.
// - One register 0 write may carry command, pointer, or both; both act.
// - Channel reset clears the pointer; host should not mix it with a pointer.
// - After a nonzero pointer, next control write goes there, then pointer clears.
// - Three status registers per channel, readable at any time.
// - Status register 2 is the only writable status register, shared by channels.
// - Register map: 1 interrupt, 2A bus, 2B vector, 3 rx, 4 mode, 5 tx, 6/7 sync.
// - Status register 0 reports external inputs, receiver phase and buffer status.
// - Chip select low; control path when cd_sel high, data path when low; ch_sel high is B.
// - Command 010 resets the channel's external/status report latch.
// - Channel reset zeroes the channel's registers and holds its transmit line marking.
module dcira_bank
    import dcira_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Host bus
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic ch_sel,
    input wire logic cd_sel,
    input wire logic [7:0] host_din,
    output logic [7:0] host_dout,
    output logic host_doe,
    // Data path toward channel engines
    output logic [1:0] data_wr_stb,
    output logic [1:0] data_rd_stb,
    input wire logic [1:0][7:0] data_rd_val,
    // Channel status inputs
    input wire logic [1:0][7:0] ext_status,
    input wire logic [1:0][7:0] rx_char_status,
    // Register contents toward the channel engines
    output logic [1:0][7:1][7:0] ctrl_regs,
    output logic [7:0] bus_iface_ctrl,
    output logic [1:0] cmd_stb,
    output logic [1:0][2:0] cmd_code,
    output logic [1:0][1:0] crc_cmd,
    output logic [1:0] tx_mark_hold
);
    // Strobe history and the mark hold travel with the register image
    typedef struct packed {
        dcira_state_t regs;
        logic wr_n_d;
        logic rd_n_d;
        logic [1:0] mark_hold;
    } dcira_bank_state_t;

    localparam dcira_bank_state_t DCIRA_BANK_RST = '{
        regs: '0,
        wr_n_d: 1'b1,
        rd_n_d: 1'b1,
        mark_hold: 2'b11
    };

    dcira_bank_state_t s_r;
    dcira_bank_state_t s_nxt;

    logic wr_pulse;
    logic rd_pulse;
    logic ctl_wr;
    logic ch;
    logic [2:0] din_ptr;
    logic [2:0] din_cmd;
    logic [1:0] din_crc;
    logic [1:0] cmd_hit;
    logic [1:0] ch_rst_cmd;
    logic to_shared_2a;
    logic to_vector;

    // True when the channel select line picks channel c
    function automatic logic chan_hit(input logic sel, input int c);
        return sel == c[0];
    endfunction : chan_hit

    // Register 0 is addressed whenever that channel's pointer rests at zero
    function automatic logic at_main_reg(input dcira_state_t st, input logic c);
        return st.ptr[c] == DCIRA_CR0;
    endfunction : at_main_reg

    function automatic dcira_byte_t status_mux(input dcira_state_t st, input logic c,
                                              input logic [1:0][7:0] rxs, input logic [2:0] p);
        dcira_byte_t v;
        v = 8'h00;
        unique case (p)
            DCIRA_SR0: v = st.ext_snap[c];
            DCIRA_SR1: v = rxs[c];
            DCIRA_SR2: v = st.shared_status;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : status_mux

    // Host strobes are synchronous levels; act once on the falling edge
    assign wr_pulse = !cs_n && !wr_n && s_r.wr_n_d;
    assign rd_pulse = !cs_n && !rd_n && s_r.rd_n_d;
    assign ctl_wr = wr_pulse && cd_sel;
    assign ch = ch_sel;
    assign din_ptr = host_din[DCIRA_PTR_LSB +: 3];
    assign din_cmd = host_din[DCIRA_CMD_LSB +: 3];
    assign din_crc = host_din[DCIRA_CRC_LSB +: 2];

    // Register 2 of channel A is the shared bus register, of channel B the vector
    assign to_shared_2a = s_r.regs.ptr[ch] == DCIRA_CR2 && !ch;
    assign to_vector = s_r.regs.ptr[ch] == DCIRA_CR2 && ch;

    // A register 0 write on channel c carries a command
    always_comb begin
        for (int c = 0; c < DCIRA_NUM_CH; c++) begin
            cmd_hit[c] = ctl_wr && chan_hit(ch, c) && at_main_reg(s_r.regs, ch);
            ch_rst_cmd[c] = cmd_hit[c] && din_cmd == DCIRA_CMD_CH_RST;
        end
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.wr_n_d = wr_n;
        s_nxt.rd_n_d = rd_n;

        // Latch holds a snapshot until command 010 or a channel reset re-arms it
        for (int c = 0; c < DCIRA_NUM_CH; c++) begin
            if (!s_r.regs.ext_latch[c]) begin
                s_nxt.regs.ext_snap[c] = ext_status[c];
                if (ext_status[c] != s_r.regs.ext_snap[c]) begin
                    s_nxt.regs.ext_latch[c] = 1'b1;
                end
            end
        end

        // Status reads go through the pointer and then release it
        if (rd_pulse) begin
            if (cd_sel) begin
                s_nxt.regs.rd_data = status_mux(s_r.regs, ch, rx_char_status, s_r.regs.ptr[ch]);
                s_nxt.regs.ptr[ch] = DCIRA_PTR_RST;
            end else begin
                s_nxt.regs.rd_data = data_rd_val[ch];
            end
        end

        if (ctl_wr) begin
            if (at_main_reg(s_r.regs, ch)) begin
                // Command and pointer fields both act, except a channel reset clears the pointer
                s_nxt.regs.ptr[ch] = din_ptr;
                unique case (din_cmd)
                    DCIRA_CMD_RST_EXT: begin
                        s_nxt.regs.ext_latch[ch] = 1'b0;
                        s_nxt.regs.ext_snap[ch] = ext_status[ch];
                    end
                    DCIRA_CMD_CH_RST: begin
                        s_nxt.regs.cr[ch] = '0;
                        s_nxt.regs.ext_latch[ch] = 1'b0;
                        if (ch) begin
                            // The vector belongs to channel B, so its status copy clears too
                            s_nxt.regs.shared_status = DCIRA_REG_RST;
                        end
                        // Reset wins over any pointer sent with it
                        s_nxt.regs.ptr[ch] = DCIRA_PTR_RST;
                    end
                    default: ;
                endcase
            end else begin
                // Indirect write, then back to register 0
                if (to_shared_2a) begin
                    s_nxt.regs.shared_bus_interface_control = host_din;
                end else begin
                    s_nxt.regs.cr[ch][s_r.regs.ptr[ch]] = host_din;
                end
                if (to_vector) begin
                    s_nxt.regs.shared_status = host_din;
                end
                s_nxt.regs.ptr[ch] = DCIRA_PTR_RST;
            end
        end

        // Transmit line marks from reset until the transmitter is enabled
        for (int c = 0; c < DCIRA_NUM_CH; c++) begin
            if (ch_rst_cmd[c]) begin
                s_nxt.mark_hold[c] = 1'b1;
            end else if (s_nxt.regs.cr[c][DCIRA_CR5][DCIRA_TX_EN_BIT]) begin
                s_nxt.mark_hold[c] = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_r <= DCIRA_BANK_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Strobes decoded per channel from the same access
    always_comb begin
        for (int c = 0; c < DCIRA_NUM_CH; c++) begin
            data_wr_stb[c] = wr_pulse && !cd_sel && chan_hit(ch, c);
            data_rd_stb[c] = rd_pulse && !cd_sel && chan_hit(ch, c);
            cmd_stb[c] = cmd_hit[c];
            cmd_code[c] = din_cmd;
            crc_cmd[c] = din_crc;
            tx_mark_hold[c] = s_r.mark_hold[c] ? DCIRA_MARK : !DCIRA_MARK;
        end
    end

    assign ctrl_regs = s_r.regs.cr;
    assign bus_iface_ctrl = s_r.regs.shared_bus_interface_control;
    assign host_dout = s_r.regs.rd_data;
    assign host_doe = !cs_n && !rd_n;
endmodule : dcira_bank

/* dv/dcira_props.sv */
// Assertions on the bank's host side
`timescale 1ns/1ps
module dcira_props
    import dcira_pkg::*;
(
    // Clock, reset, host bus and outputs
    input logic sys_clk,
    input logic rst,
    input logic cs_n,
    input logic rd_n,
    input logic wr_n,
    input logic ch_sel,
    input logic cd_sel,
    input logic [7:0] host_din,
    input logic host_doe,
    input logic [1:0] data_wr_stb,
    input logic [1:0] data_rd_stb,
    input logic [1:0] cmd_stb,
    input logic [1:0][2:0] cmd_code,
    input logic [1:0] tx_mark_hold,
    input logic [7:0] bus_iface_ctrl
);
    logic wr_d_r;
    // Own strobe history, so a held strobe is not taken twice
    always_ff @(posedge sys_clk or posedge rst) wr_d_r <= rst ? 1'b1 : wr_n;
    wire wt = !cs_n && !wr_n && wr_d_r;
    wire cw = wt && cd_sel;
    wire [1:0] sel = ch_sel ? 2'h2 : 2'h1;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_doe_level: assert property (host_doe == (!cs_n && !rd_n)) else $error("doe");
    a_data_write: assert property (data_wr_stb == (wt && !cd_sel ? sel : 2'h0)) else $error("dwr");
    a_data_read: assert property (|data_rd_stb |-> !cd_sel && data_rd_stb == sel) else $error("drd");
    a_cmd_source: assert property (|cmd_stb |-> cw && cmd_stb == sel) else $error("cmd");
    a_cmd_field: assert property (|cmd_stb |-> cmd_code[ch_sel] == host_din[5:3]) else $error("code");
    a_chan_reset: assert property (cmd_stb[1] && cmd_code[1] == DCIRA_CMD_CH_RST |=> tx_mark_hold[1])
        else $error("mark");
    a_shared_hold: assert property (!cw ##1 !cw |=> $stable(bus_iface_ctrl)) else $error("bus");
    a_held_write: assert property (!wr_n && !wr_d_r |-> !cmd_stb && !data_wr_stb) else $error("held");
    c_chan_reset: cover property (cmd_stb[1] && cmd_code[1] == DCIRA_CMD_CH_RST);
    c_data_read: cover property (|data_rd_stb);
    c_cmd_a: cover property (cmd_stb[0]);
endmodule : dcira_props
bind dcira_bank dcira_props u_props (.*);

/* dv/dcira_host.sv */
// Host processor model on the parallel bus
`timescale 1ns/1ps
module dcira_host (
    // Clock and bus
    input logic sys_clk,
    output logic cs_n = 1'b1,
    output logic rd_n = 1'b1,
    output logic wr_n = 1'b1,
    output logic ch_sel = 1'b0,
    output logic cd_sel = 1'b0,
    output logic [7:0] host_din = 8'h00,
    input logic [7:0] host_dout
);
    // Strobe one cycle, then idle two cycles before the next access
    task automatic acc(input logic w, c, d, input logic [7:0] v, output logic [7:0] r);
        @(posedge sys_clk);
        cs_n <= 1'b0;
        wr_n <= !w;
        rd_n <= w;
        ch_sel <= c;
        cd_sel <= d;
        host_din <= v;
        @(posedge sys_clk);
        cs_n <= 1'b1;
        wr_n <= 1'b1;
        rd_n <= 1'b1;
        host_din <= ~v;
        @(posedge sys_clk);
        r = host_dout;
    endtask : acc
endmodule : dcira_host

/* dv/test_dual_channel_indirect_register_access.sv */
// Bench for the register bank
`timescale 1ns/1ps
module test_dual_channel_indirect_register_access
    import dcira_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic cs_n, rd_n, wr_n, ch_sel, cd_sel, host_doe;
    logic [7:0] host_din, host_dout, bus_iface_ctrl, rv, xv, mb = 8'h00;
    logic [1:0] data_wr_stb, data_rd_stb, cmd_stb, tx_mark_hold;
    logic [1:0][7:0] data_rd_val = '0, ext_status = '0, rx_char_status = '0;
    logic [1:0][7:1][7:0] ctrl_regs, m = '0;
    logic [1:0][2:0] cmd_code;
    logic [1:0][1:0] crc_cmd;
    logic [15:0] sd = 16'h4D71;
    int err_count = 0;
    int tests_run = 0;
    int ord[7] = '{2, 4, 1, 3, 5, 6, 7};
    dcira_bank u_dcira_bank (.*);
    dcira_host u_dcira_host (.*);
    always #5 sys_clk = ~sys_clk;
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic chk(input string n, input logic [127:0] s, e);
        tests_run++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic report_and_stop;
        if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    task automatic cmp;
        #1;
        chk("regs", {ctrl_regs[1], ctrl_regs[0][7:3], ctrl_regs[0][1], bus_iface_ctrl},
            {m[1], m[0][7:3], m[0][1], mb});
    endtask : cmp
    task automatic iwr(input logic c, input logic [2:0] r, input logic [7:0] v);
        u_dcira_host.acc(1'b1, c, 1'b1, {5'h00, r}, rv);
        u_dcira_host.acc(1'b1, c, 1'b1, v, rv);
        if (!c && r == DCIRA_CR2) mb = v;
        else m[c][r] = v;
    endtask : iwr
    task automatic srd(input logic c, input logic [2:0] r, output logic [7:0] v);
        u_dcira_host.acc(1'b1, c, 1'b1, {5'h00, r}, rv);
        u_dcira_host.acc(1'b0, c, 1'b1, 8'h00, v);
    endtask : srd
    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        cmp;
        chk("mark", tx_mark_hold, 2'h3);
        for (int c = 0; c < 2; c++) begin
            foreach (ord[i]) begin
                sd = lfsr(sd);
                iwr(c[0], ord[i][2:0], sd[7:0]);
                cmp;
            end
        end
        u_dcira_host.acc(1'b1, 1'b1, 1'b1, {2'h0, DCIRA_CMD_RST_EXT, DCIRA_CR5}, rv);
        u_dcira_host.acc(1'b1, 1'b1, 1'b1, 8'hA5, rv);
        m[1][5] = 8'hA5;
        cmp;
        // Pointer field left zero so the reset is not mixed with it
        u_dcira_host.acc(1'b1, 1'b1, 1'b1, {2'h0, DCIRA_CMD_CH_RST, 3'h0}, rv);
        m[1] = '0;
        cmp;
        chk("mark_b", tx_mark_hold[1], 1'b1);
        iwr(1'b1, DCIRA_CR6, 8'h3C);
        cmp;
        u_dcira_host.acc(1'b1, 1'b0, 1'b0, sd[7:0], rv);
        for (int c = 0; c < 2; c++) begin
            sd = lfsr(sd);
            rx_char_status[c] <= sd[7:0];
            data_rd_val[c] <= sd[15:8];
            ext_status[c] <= sd[15:8] | 8'h01;
            srd(c[0], DCIRA_SR1, rv);
            chk("sr1", rv, sd[7:0]);
            u_dcira_host.acc(1'b0, c[0], 1'b0, 8'h00, rv);
            chk("data", rv, sd[15:8]);
            xv = ~sd[15:8];
            ext_status[c] <= xv;
            srd(c[0], DCIRA_SR0, rv);
            chk("sr0_held", rv, sd[15:8] | 8'h01);
            u_dcira_host.acc(1'b1, c[0], 1'b1, {2'h0, DCIRA_CMD_RST_EXT, 3'h0}, rv);
            srd(c[0], DCIRA_SR0, rv);
            chk("sr0_rearm", rv, xv);
            iwr(1'b1, DCIRA_CR2, sd[7:0] ^ 8'h5A);
            cmp;
            srd(c[0], DCIRA_SR2, rv);
            chk("sr2", rv, m[1][2]);
        end
        report_and_stop;
    end
endmodule : test_dual_channel_indirect_register_access
